// [bst_chain.sv]
// Boundary chain: two stages per I/O site, pad inputs synchronised
`timescale 1ns/1ps
module bst_chain (
   // Clock and reset
   input  wire logic                            clk,
   input  wire logic                            rst_b,
   // Site levels
   input  wire bst_pkg::bst_site_t              site,
   // Control from the controller
   input  wire logic                            capture,
   input  wire logic                            shift,
   input  wire logic                            intest,
   // Serial path
   input  wire logic                            serial_in,
   output logic                                 serial_out,
   output logic [bst_pkg::BST_CHAIN_W-1:0]      chain
);

   localparam int N = bst_pkg::BST_SITES;
   localparam int W = bst_pkg::BST_CHAIN_W;

   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
      logic [N-1:0] pin;
      logic [W-1:0] sr;
   } bst_chain_state_t;

   bst_chain_state_t st_reg;
   bst_chain_state_t st_next;
   logic [W-1:0]     cap_word;
   logic [N-1:0]     agree;

   // Pad level counts once stages two and three agree
   assign agree = ~(st_reg.s2 ^ st_reg.s3);

   // Per site: capture word in, grouped update word out
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_site
         assign cap_word[i*bst_pkg::BST_CELL_W + bst_pkg::BST_CELL_DATA] =
            intest ? site.core_out[i] : st_reg.pin[i];
         assign cap_word[i*bst_pkg::BST_CELL_W + bst_pkg::BST_CELL_EN] = site.core_oe[i];
         assign chain[i]     = st_reg.sr[i*bst_pkg::BST_CELL_W + bst_pkg::BST_CELL_DATA];
         assign chain[N + i] = st_reg.sr[i*bst_pkg::BST_CELL_W + bst_pkg::BST_CELL_EN];
      end
   endgenerate

   assign serial_out = st_reg.sr[0];

   // Synchronisers, capture and shift; shift moves one stage, two per site
   always_comb begin
      st_next     = st_reg;
      st_next.s1  = site.pin_in;
      st_next.s2  = st_reg.s1;
      st_next.s3  = st_reg.s2;
      st_next.pin = (agree & st_reg.s3) | (~agree & st_reg.pin);
      if (capture) begin
         st_next.sr = cap_word;
      end else if (shift) begin
         st_next.sr = {serial_in, st_reg.sr[W-1:1]};
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

endmodule

// [bst_ctl.sv]
// Test controller model driving the port pins
`timescale 1ns/1ps
module bst_ctl (
   // Clock
   input  wire logic clk,
   // Test-port pins
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   output logic      test_reset_n,
   input  wire logic tdo
);
   initial begin
      tck = 1'b1;
      tms = 1'b1;
      tdi = 1'b0;
      test_reset_n = 1'b1;
   end
   // One 400 ns clock per step; rests high between steps
   task automatic step(input logic m, input logic d, output logic q);
      @(posedge clk);
      #1 tck = 1'b0;
      tms = m;
      tdi = d;
      repeat (4) @(posedge clk);
      #1 tck = 1'b1;
      repeat (3) @(posedge clk);
      q = tdo;
   endtask
endmodule

// [bst_pkg.sv]
// Constants, types and decode helpers for the test port
package bst_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int BST_IR_W    = 3;
   localparam int BST_ID_W    = 32;
   localparam int BST_SITES   = 8;               // I/O sites with a boundary cell
   localparam int BST_CELL_W  = 2;               // Stages per site
   localparam int BST_CHAIN_W = BST_SITES * BST_CELL_W;
   localparam int BST_SYNC_W  = 4;               // Synchronised port pins
   localparam int BST_PINS    = 5;               // Shared test-port pins
   localparam int BST_BUF_D   = 2;               // Update buffer depth

   ////////////////////////////////////////////////////////////////////////////
   // Shared pin positions
   localparam int BST_PIN_TCK  = 0;
   localparam int BST_PIN_TMS  = 1;
   localparam int BST_PIN_TDI  = 2;
   localparam int BST_PIN_TRST = 3;
   localparam int BST_PIN_TDO  = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Chain layout: site i holds value at 2i, enable at 2i+1
   localparam int BST_CELL_DATA = 0;
   localparam int BST_CELL_EN   = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction codes
   localparam logic [BST_IR_W-1:0] BST_IR_EXTEST  = 3'h0;
   localparam logic [BST_IR_W-1:0] BST_IR_INTEST  = 3'h1;
   localparam logic [BST_IR_W-1:0] BST_IR_SAMPLE  = 3'h2;
   localparam logic [BST_IR_W-1:0] BST_IR_IDCODE  = 3'h4;
   localparam logic [BST_IR_W-1:0] BST_IR_BYPASS  = 3'h7;
   localparam logic [BST_IR_W-1:0] BST_IR_CAPTURE = 3'h1;   // Low two bits 01

   ////////////////////////////////////////////////////////////////////////////
   // Identification register fields
   localparam int BST_ID_MFR_W  = 12;            // Bits 0..11
   localparam int BST_ID_ARR_W  = 10;            // Bits 12..21
   localparam int BST_ID_PROD_W = 6;             // Bits 22..27
   localparam int BST_ID_VER_W  = 4;             // Bits 28..31

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {
      BST_SEL_CHAIN,
      BST_SEL_ID,
      BST_SEL_BYPASS
   } bst_dsel_t;

   typedef enum logic [3:0] {
      BST_TLR, BST_RTI,
      BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR, BST_PA_DR, BST_EX2_DR, BST_UPD_DR,
      BST_SEL_IR, BST_CAP_IR, BST_SH_IR, BST_EX1_IR, BST_PA_IR, BST_EX2_IR, BST_UPD_IR
   } bst_tap_t;

   typedef struct packed {
      logic [BST_SITES-1:0] pin_in;              // Level seen at each pad
      logic [BST_SITES-1:0] core_out;            // Core value for each pad
      logic [BST_SITES-1:0] core_oe;             // Core enable for each pad
   } bst_site_t;

   typedef struct packed {
      logic [BST_SITES-1:0] en;
      logic [BST_SITES-1:0] data;
   } bst_upd_t;

   ////////////////////////////////////////////////////////////////////////////
   // Data path for an instruction; unlisted codes act as bypass
   function automatic bst_dsel_t bst_decode(input logic [BST_IR_W-1:0] ir);
      bst_dsel_t sel;
      unique case (ir)
         BST_IR_EXTEST, BST_IR_INTEST, BST_IR_SAMPLE : sel = BST_SEL_CHAIN;
         BST_IR_IDCODE                               : sel = BST_SEL_ID;
         default                                     : sel = BST_SEL_BYPASS;
      endcase
      return sel;
   endfunction

   // Next controller state for one rising test-clock edge
   function automatic bst_tap_t bst_tap_next(input bst_tap_t s, input logic tms);
      bst_tap_t n;
      unique case (s)
         BST_TLR    : n = tms ? BST_TLR    : BST_RTI;
         BST_RTI    : n = tms ? BST_SEL_DR : BST_RTI;
         BST_SEL_DR : n = tms ? BST_SEL_IR : BST_CAP_DR;
         BST_CAP_DR : n = tms ? BST_EX1_DR : BST_SH_DR;
         BST_SH_DR  : n = tms ? BST_EX1_DR : BST_SH_DR;
         BST_EX1_DR : n = tms ? BST_UPD_DR : BST_PA_DR;
         BST_PA_DR  : n = tms ? BST_EX2_DR : BST_PA_DR;
         BST_EX2_DR : n = tms ? BST_UPD_DR : BST_SH_DR;
         BST_UPD_DR : n = tms ? BST_SEL_DR : BST_RTI;
         BST_SEL_IR : n = tms ? BST_TLR    : BST_CAP_IR;
         BST_CAP_IR : n = tms ? BST_EX1_IR : BST_SH_IR;
         BST_SH_IR  : n = tms ? BST_EX1_IR : BST_SH_IR;
         BST_EX1_IR : n = tms ? BST_UPD_IR : BST_PA_IR;
         BST_PA_IR  : n = tms ? BST_EX2_IR : BST_PA_IR;
         BST_EX2_IR : n = tms ? BST_UPD_IR : BST_SH_IR;
         BST_UPD_IR : n = tms ? BST_SEL_DR : BST_RTI;
      endcase
      return n;
   endfunction

endpackage

// [bst_tap.sv]
// Boundary-scan test port: controller, instruction, bypass, identity, chain
//
// Contract
// - Five test pins shared with user signals
// - Pins return to user I/O when disabled
// - Capture, shift and update follow the test clock; buffered words reach the pads on upd_ready in external test only
// - Sixteen-state synchronous port controller
// - Three-bit serial instruction register, decoded
// - Codes select chain, identity or bypass
// - External test drives and observes pins
// - Internal test stimulates and captures core
// - Sample captures pins without disturbing them
// - Identity code shifts out on output
// - Bypass passes data through one stage
// - Bypass register is one bit
// - Identity is 32 bits, four fields
// - Chain shifts on clock while selected
// - Chain runs through sites to output
// - Two stages per site: value, enable
// - Data moves one site per two shifts
// - Test pins themselves carry no cell
`timescale 1ns/1ps
module bst_tap #(
   // Identity fields; values are arbitrary
   parameter logic [bst_pkg::BST_ID_MFR_W-1:0]  ID_MFR  = 12'h0A5,
   parameter logic [bst_pkg::BST_ID_ARR_W-1:0]  ID_ARR  = 10'h001,
   parameter logic [bst_pkg::BST_ID_PROD_W-1:0] ID_PROD = 6'h01,
   parameter logic [bst_pkg::BST_ID_VER_W-1:0]  ID_VER  = 4'h1
) (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst_b,
   // Shared test-port pins
   input  wire logic [bst_pkg::BST_PINS-1:0]   pin_in,
   output logic      [bst_pkg::BST_PINS-1:0]   pin_out,
   output logic      [bst_pkg::BST_PINS-1:0]   pin_oe,
   // Pin reuse control
   input  wire logic                           test_pins_enable,
   // User side of the shared pins
   input  wire logic [bst_pkg::BST_PINS-1:0]   user_out,
   input  wire logic [bst_pkg::BST_PINS-1:0]   user_oe,
   output logic      [bst_pkg::BST_PINS-1:0]   user_in,
   // I/O sites
   input  wire bst_pkg::bst_site_t             site,
   output logic      [bst_pkg::BST_SITES-1:0]  pad_out,
   output logic      [bst_pkg::BST_SITES-1:0]  pad_oe,
   output logic      [bst_pkg::BST_SITES-1:0]  core_in,
   // Update word stream
   output logic                                upd_valid,
   input  wire logic                           upd_ready,
   output bst_pkg::bst_upd_t                   upd_data,
   output logic                                upd_space,
   // Status
   output logic                                tap_reset_active,
   output logic                                ir_path_select,
   output logic      [bst_pkg::BST_IR_W-1:0]   instr
);

   localparam int SW = bst_pkg::BST_SYNC_W;
   localparam int CW = bst_pkg::BST_CHAIN_W;
   localparam logic [bst_pkg::BST_ID_W-1:0] ID_CODE = {ID_VER, ID_PROD, ID_ARR, ID_MFR};

   typedef struct packed {
      logic [SW-1:0]                  s1;
      logic [SW-1:0]                  s2;
      logic [SW-1:0]                  s3;
      logic [SW-1:0]                  filt;
      bst_pkg::bst_tap_t              tap;
      logic [bst_pkg::BST_IR_W-1:0]   ir_sh;
      logic [bst_pkg::BST_IR_W-1:0]   ir_act;
      logic                           bypass;
      logic [bst_pkg::BST_ID_W-1:0]   id_sh;
      logic                           tdo;
      logic                           tdo_oe;
      bst_pkg::bst_upd_t              applied;
      logic [bst_pkg::BST_SITES-1:0]  pad_out;
      logic [bst_pkg::BST_SITES-1:0]  pad_oe;
      logic [bst_pkg::BST_SITES-1:0]  core_in;
   } bst_tap_state_t;

   bst_tap_state_t     st_reg;
   bst_tap_state_t     st_next;
   logic [SW-1:0]      agree;
   logic [SW-1:0]      lvl;
   logic               tck_rise;
   logic               tck_fall;
   logic               test_reset;
   bst_pkg::bst_dsel_t dsel;
   logic               is_extest;
   logic               is_intest;
   logic               dr_shift_clock;
   logic               dr_shift_select;
   logic               dr_update_strobe;
   logic               ir_shift_clock;
   logic               ir_shift_select;
   logic               ir_update_strobe;
   logic               chain_sel;
   logic               chain_out;
   logic [CW-1:0]      chain_word;
   logic               buf_in_ready;
   logic               buf_out_valid;
   bst_pkg::bst_upd_t  buf_out_data;
   logic               dr_serial;

   ////////////////////////////////////////////////////////////////////////////
   // Pin sampling

   // A level counts once stages two and three agree
   assign agree = ~(st_reg.s2 ^ st_reg.s3);
   assign lvl   = (agree & st_reg.s3) | (~agree & st_reg.filt);

   // Test-clock edges found by the system clock
   assign tck_rise = lvl[bst_pkg::BST_PIN_TCK] & ~st_reg.filt[bst_pkg::BST_PIN_TCK];
   assign tck_fall = ~lvl[bst_pkg::BST_PIN_TCK] & st_reg.filt[bst_pkg::BST_PIN_TCK];

   // User mode holds the controller in reset
   assign test_reset = ~lvl[bst_pkg::BST_PIN_TRST] | ~test_pins_enable;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction decode and controller strobes

   assign dsel      = bst_pkg::bst_decode(st_reg.ir_act);
   assign chain_sel = (dsel == bst_pkg::BST_SEL_CHAIN);
   assign is_extest = (st_reg.ir_act == bst_pkg::BST_IR_EXTEST);
   assign is_intest = (st_reg.ir_act == bst_pkg::BST_IR_INTEST);

   assign dr_shift_select  = (st_reg.tap == bst_pkg::BST_SH_DR);
   assign ir_shift_select  = (st_reg.tap == bst_pkg::BST_SH_IR);
   assign dr_shift_clock   = tck_rise & ~test_reset &
                             (dr_shift_select | (st_reg.tap == bst_pkg::BST_CAP_DR));
   assign ir_shift_clock   = tck_rise & ~test_reset &
                             (ir_shift_select | (st_reg.tap == bst_pkg::BST_CAP_IR));
   assign dr_update_strobe = tck_fall & ~test_reset & (st_reg.tap == bst_pkg::BST_UPD_DR);
   assign ir_update_strobe = tck_fall & ~test_reset & (st_reg.tap == bst_pkg::BST_UPD_IR);

   assign tap_reset_active = (st_reg.tap == bst_pkg::BST_TLR);
   assign ir_path_select   = (st_reg.tap >= bst_pkg::BST_SEL_IR);
   assign instr            = st_reg.ir_act;

   // Serial source of the data path in use
   always_comb begin
      unique case (dsel)
         bst_pkg::BST_SEL_CHAIN : dr_serial = chain_out;
         bst_pkg::BST_SEL_ID    : dr_serial = st_reg.id_sh[0];
         default                : dr_serial = st_reg.bypass;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Boundary chain; the port pins have no cell

   bst_chain u_chain (
      .clk        (clk),
      .rst_b      (rst_b),
      .site       (site),
      .capture    (dr_shift_clock & ~dr_shift_select & chain_sel),
      .shift      (dr_shift_clock & dr_shift_select & chain_sel),
      .intest     (is_intest),
      .serial_in  (lvl[bst_pkg::BST_PIN_TDI]),
      .serial_out (chain_out),
      .chain      (chain_word)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Update words: two entries absorb a pad-ring stall

   bst_upd_buf #(
      .WIDTH (CW),
      .DEPTH (bst_pkg::BST_BUF_D)
   ) u_buf (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_valid  (dr_update_strobe & chain_sel),
      .in_ready  (buf_in_ready),
      .in_data   (chain_word),
      .out_valid (buf_out_valid),
      .out_ready (upd_ready),
      .out_data  (buf_out_data)
   );

   assign upd_valid = buf_out_valid;
   assign upd_data  = buf_out_data;
   assign upd_space = buf_in_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Controller, registers and serial output
   always_comb begin
      st_next      = st_reg;
      st_next.s1   = pin_in[SW-1:0];
      st_next.s2   = st_reg.s1;
      st_next.s3   = st_reg.s2;
      st_next.filt = lvl;

      if (test_reset) begin
         // Reset state, identity path selected
         st_next.tap    = bst_pkg::BST_TLR;
         st_next.ir_act = bst_pkg::BST_IR_IDCODE;
         st_next.tdo_oe = 1'b0;
      end else begin
         // Rising edge: capture or shift, then step the controller
         if (tck_rise) begin
            unique case (st_reg.tap)
               bst_pkg::BST_TLR : begin
                  st_next.ir_act = bst_pkg::BST_IR_IDCODE;
               end
               bst_pkg::BST_CAP_IR : begin
                  st_next.ir_sh = bst_pkg::BST_IR_CAPTURE;
               end
               bst_pkg::BST_SH_IR : begin
                  st_next.ir_sh = {lvl[bst_pkg::BST_PIN_TDI], st_reg.ir_sh[bst_pkg::BST_IR_W-1:1]};
               end
               bst_pkg::BST_CAP_DR : begin
                  st_next.bypass = 1'b0;
                  st_next.id_sh  = ID_CODE;
               end
               bst_pkg::BST_SH_DR : begin
                  if (dsel == bst_pkg::BST_SEL_ID) begin
                     st_next.id_sh = {lvl[bst_pkg::BST_PIN_TDI], st_reg.id_sh[bst_pkg::BST_ID_W-1:1]};
                  end else if (dsel == bst_pkg::BST_SEL_BYPASS) begin
                     st_next.bypass = lvl[bst_pkg::BST_PIN_TDI];
                  end
               end
               default : begin
               end
            endcase
            st_next.tap = bst_pkg::bst_tap_next(st_reg.tap, lvl[bst_pkg::BST_PIN_TMS]);
         end

         // Falling edge: output changes, instruction takes effect
         if (tck_fall) begin
            st_next.tdo_oe = ir_shift_select | dr_shift_select;
            if (ir_shift_select) begin
               st_next.tdo = st_reg.ir_sh[0];
            end else if (dr_shift_select) begin
               st_next.tdo = dr_serial;
            end
            if (ir_update_strobe) begin
               st_next.ir_act = st_reg.ir_sh;
            end
         end
      end

      // Applied values follow each word taken
      if (buf_out_valid && upd_ready) begin
         st_next.applied = buf_out_data;
      end

      // Pad and core muxing; sample leaves the normal path untouched
      st_next.pad_out = is_extest ? st_reg.applied.data : site.core_out;
      st_next.pad_oe  = is_extest ? st_reg.applied.en : site.core_oe;
      st_next.core_in = is_intest ? st_reg.applied.data : site.pin_in;
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg        <= '0;
         st_reg.tap    <= bst_pkg::BST_TLR;
         st_reg.ir_act <= bst_pkg::BST_IR_IDCODE;
         {st_reg.s1, st_reg.s2, st_reg.s3, st_reg.filt} <= '1;  // Pins idle high: no false edge
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared pins: test port or user I/O
   always_comb begin
      pin_out = user_out;
      pin_oe  = user_oe;
      if (test_pins_enable) begin
         pin_out = '0;
         pin_oe  = '0;
         pin_out[bst_pkg::BST_PIN_TDO] = st_reg.tdo;
         pin_oe[bst_pkg::BST_PIN_TDO]  = st_reg.tdo_oe;
      end
   end

   // User logic always sees the pins
   assign user_in = pin_in;

   assign pad_out = st_reg.pad_out;
   assign pad_oe  = st_reg.pad_oe;
   assign core_in = st_reg.core_in;

endmodule

// [bst_tap_monitor.sv]
// Assertions for the boundary-scan test port
`timescale 1ns/1ps
module bst_tap_monitor (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_b,
   // Shared pins
   input  wire logic [bst_pkg::BST_PINS-1:0] pin_in,
   input  wire logic [bst_pkg::BST_PINS-1:0] pin_out,
   input  wire logic [bst_pkg::BST_PINS-1:0] pin_oe,
   input  wire logic                         test_pins_enable,
   input  wire logic [bst_pkg::BST_PINS-1:0] user_out,
   input  wire logic [bst_pkg::BST_PINS-1:0] user_oe,
   input  wire logic [bst_pkg::BST_PINS-1:0] user_in,
   // Update stream and status
   input  wire logic                         upd_valid,
   input  wire logic                         upd_ready,
   input  wire bst_pkg::bst_upd_t            upd_data,
   input  wire logic                         upd_space,
   input  wire logic                         tap_reset_active,
   input  wire logic                         ir_path_select,
   input  wire logic [bst_pkg::BST_IR_W-1:0] instr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////
   // Pin sharing
   a_user_in_mirror: assert property (user_in == pin_in)
      else $error("user_in not pins");
   a_user_mode_pins: assert property (!test_pins_enable |-> pin_out == user_out && pin_oe == user_oe)
      else $error("user drive lost");
   a_test_pins_input: assert property (test_pins_enable && $past(test_pins_enable) |-> pin_oe[3:0] == 4'h0)
      else $error("input test pin driven");
   ////////////////////////////////////////////////////////////////////////////
   // Controller and instruction
   a_tlr_idcode: assert property (tap_reset_active && $past(tap_reset_active) |-> instr == bst_pkg::BST_IR_IDCODE)
      else $error("reset instr not identity");
   a_tlr_tdo_off: assert property (test_pins_enable && tap_reset_active && $past(tap_reset_active) |-> !pin_oe[4])
      else $error("output driven in reset");
   a_state_excl: assert property (ir_path_select |-> !tap_reset_active)
      else $error("two controller states at once");
   a_instr_change: assert property ($changed(instr) |-> $past(ir_path_select) || $past(tap_reset_active) ||
                                    tap_reset_active)
      else $error("instr changed outside column");
   ////////////////////////////////////////////////////////////////////////////
   // Update buffer; instruction-column cover
   a_upd_hold: assert property (upd_valid && !upd_ready |=> upd_valid && $stable(upd_data))
      else $error("stalled word moved");
   a_full_valid: assert property (!upd_space |-> upd_valid)
      else $error("buffer full but nothing valid");
   c_pop: cover property (upd_valid && upd_ready);
   c_full: cover property (!upd_space);
   c_ir_col: cover property (ir_path_select);
endmodule
bind bst_tap bst_tap_monitor u_mon (.clk, .rst_b, .pin_in, .pin_out, .pin_oe, .test_pins_enable, .user_out,
   .user_oe, .user_in, .upd_valid, .upd_ready, .upd_data, .upd_space, .tap_reset_active, .ir_path_select, .instr);

// [bst_upd_buf.sv]
// Two-entry valid/ready buffer for boundary update words
`timescale 1ns/1ps
module bst_upd_buf #(
   parameter int WIDTH = bst_pkg::BST_CHAIN_W,
   parameter int DEPTH = bst_pkg::BST_BUF_D
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wptr;
      logic [PW-1:0]               rptr;
      logic [CW-1:0]               count;
   } bst_buf_state_t;

   bst_buf_state_t st_reg;
   bst_buf_state_t st_next;
   logic           push;
   logic           pop;

   // Full refuses, empty shows nothing
   assign in_ready  = (st_reg.count != CNT_FULL);
   assign out_valid = (st_reg.count != '0);
   assign out_data  = st_reg.mem[st_reg.rptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointer and count update
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wptr] = in_data;
         st_next.wptr = (st_reg.wptr == PTR_LAST) ? '0 : st_reg.wptr + PW'(1);
      end
      if (pop) begin
         st_next.rptr = (st_reg.rptr == PTR_LAST) ? '0 : st_reg.rptr + PW'(1);
      end
      if (push && !pop) begin
         st_next.count = st_reg.count + CW'(1);
      end else if (pop && !push) begin
         st_next.count = st_reg.count - CW'(1);
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

endmodule

// [tb_bst_tap.sv]
// Bench for the boundary-scan test port
`timescale 1ns/1ps
module tb_bst_tap;
   logic clk, rst_b, tpe, upd_ready, tck, tms, tdi, trn, tdo_w;
   logic [4:0] pin_out, pin_oe, user_in, user_out, user_oe;
   logic [7:0] pad_out, pad_oe, core_in;
   logic upd_valid, upd_space, tra, irs;
   logic [2:0] instr;
   bst_pkg::bst_upd_t upd_data;
   bst_pkg::bst_site_t site;
   int mismatches, compares;
   // Arbitrary identity fields
   localparam logic [31:0] ID = {4'h9, 6'h15, 10'h2C1, 12'h5A3};
   // Pull-up on the output line
   assign tdo_w = pin_oe[4] ? pin_out[4] : 1'b1;
   bst_tap #(.ID_MFR(12'h5A3), .ID_ARR(10'h2C1), .ID_PROD(6'h15), .ID_VER(4'h9)) DUT (.clk(clk), .rst_b(rst_b),
      .pin_in({tdo_w, trn, tdi, tms, tck}), .pin_out(pin_out), .pin_oe(pin_oe), .test_pins_enable(tpe),
      .user_out(user_out), .user_oe(user_oe), .user_in(user_in), .site(site), .pad_out(pad_out), .pad_oe(pad_oe),
      .core_in(core_in), .upd_valid(upd_valid), .upd_ready(upd_ready), .upd_data(upd_data), .upd_space(upd_space),
      .tap_reset_active(tra), .ir_path_select(irs), .instr(instr));
   bst_ctl ctl (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .test_reset_n(trn), .tdo(tdo_w));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic complete_run;
      if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // n steps, mode bits LSB first
   task automatic walk(input logic [3:0] m, input int n);
      logic q;
      for (int k = 0; k < n; k++) ctl.step(m[k], 1'b0, q);
   endtask
   // Shift n bits LSB first, exit via update
   task automatic sh(input int n, input logic [31:0] d, output logic [31:0] q);
      q = '0;
      for (int k = 0; k < n; k++) ctl.step(k == n - 1, d[k], q[k]);
      walk(4'h1, 2);
   endtask
   task automatic ir(input logic [2:0] c);
      logic [31:0] q;
      walk(4'h3, 4);
      sh(3, {29'h0, c}, q);
      chk("ir capture", 32'h1, q & 32'h3);
      chk("instr", {29'h0, c}, {29'h0, instr});
   endtask
   task automatic dr(input int n, input logic [31:0] d, output logic [31:0] q);
      walk(4'h1, 3);
      sh(n, d, q);
   endtask
   function automatic logic [15:0] split(input logic [15:0] w);
      for (int i = 0; i < 8; i++) begin
         split[i] = w[2*i];
         split[i+8] = w[2*i+1];
      end
   endfunction
   task automatic t_id;
      logic [31:0] q;
      chk("reset state", 32'h1, {31'h0, tra});
      walk(4'h0, 1);
      dr(32, 32'h0, q);
      chk("idcode", ID, q);
   endtask
   // Every code; bypass-like ones give one stage
   task automatic t_codes;
      logic [31:0] q;
      for (int c = 0; c < 8; c++) begin
         ir(c[2:0]);
         if (c == 3 || c > 4) begin
            dr(9, 32'hA5, q);
            chk("bypass", 32'h14A, q & 32'h1FF);
         end
      end
   endtask
   // Chain order; two words queue while stalled
   task automatic t_chain;
      logic [31:0] q;
      #1 upd_ready = 1'b0;
      ir(3'h0);
      dr(32, 32'h3C96_E14B, q);
      chk("chain out", 32'hE14B, q >> 16);
      chk("word", {16'h0, split(16'h3C96)}, {16'h0, upd_data});
      dr(16, 32'h9A5C, q);
      chk("full", 32'h0, {31'h0, upd_space});
      chk("held word", {16'h0, split(16'h3C96)}, {16'h0, upd_data});
      @(posedge clk) #1 upd_ready = 1'b1;
      repeat (8) @(posedge clk);
      chk("drained", 32'h0, {31'h0, upd_valid});
      chk("pads", {16'h0, split(16'h9A5C)}, {16'h0, pad_oe, pad_out});
   endtask
   task automatic t_treset;
      @(posedge clk) #1 ctl.test_reset_n = 1'b0;
      repeat (10) @(posedge clk);
      chk("test reset", 32'h9, {28'h0, instr, tra});
      #1 ctl.test_reset_n = 1'b1;
   endtask
   task automatic t_user;
      @(posedge clk) #1 tpe = 1'b0;
      repeat (3) @(posedge clk);
      chk("user pins", {22'h0, user_oe, user_out}, {22'h0, pin_oe, pin_out});
      chk("user in", {27'h0, tdo_w, trn, tdi, tms, tck}, {27'h0, user_in});
   endtask
   initial begin
      mismatches = 0;
      compares = 0;
      rst_b = 1'b0;
      tpe = 1'b1;
      upd_ready = 1'b1;
      user_out = 5'h15;
      user_oe = 5'h0A;
      site = {8'hC3, 8'h5A, 8'hF0};
      repeat (10) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (6) @(posedge clk);
      t_id();
      t_codes();
      t_chain();
      t_treset();
      t_user();
      complete_run();
   end
   initial begin
      #2000000;
      mismatches++;
      complete_run();
   end
endmodule
